/* logic/compare_unit.sv */
/*
  One 16-bit comparator: equality level and a one-cycle hit
  on its rising edge. Assumes count and value share ref_clk.
*/
`timescale 1ns/100ps
module compare_unit
  import timer_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  cmp_if.unit       c
);
  logic equal_ff;

  // match only once both bytes are in
  assign c.equal = c.armed && (c.count == c.value);
  assign c.hit   = c.equal && !equal_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) equal_ff <= 1'b0;
    else       equal_ff <= c.equal;
  end

  chk_hit_on_match: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (c.armed && c.count == c.value && !equal_ff) |-> c.hit)
    else $error("comparator missed a fresh match");
endmodule

/* logic/timer_compare_capture_channel.sv */
/*
  Compare/capture/toggle side of a 16-bit timer channel, with
  prescaler and up counter, behind an Avalon-MM slave.
  Assumes capture pins are asynchronous and the master holds a
  request until waitrequest is seen low.
*/
`timescale 1ns/100ps
module timer_compare_capture_channel
  import timer_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              captureInA,
  input  wire logic              captureInB,
  output logic                   timerOutA,
  output logic                   timerOutB,
  output logic                   matchIrqA,
  output logic                   matchIrqB,
  output logic                   overflowIrq,
  output logic                   extIrq
);
  bus_t        busSt_ff;
  bus_t        nxt_busSt;
  logic [7:0]  rdData_ff;
  logic [7:0]  runReg_ff;
  logic [7:0]  modeReg_ff;
  logic [7:0]  ffcrReg_ff;
  logic [4:0]  pre_ff;
  logic [15:0] uc_ff;
  logic [15:0] cmpA_ff;
  logic [15:0] cmpB_ff;
  logic [15:0] buf_ff;
  logic [15:0] capA_ff;
  logic [15:0] capB_ff;
  logic        armA_ff;
  logic        armB_ff;
  logic        bufLo_ff;
  logic        bufHi_ff;
  logic        lockA_ff;
  logic        lockB_ff;
  logic        ffA_ff;
  logic        ffB_ff;
  logic        ffAPrev_ff;
  logic [1:0]  pinMeta_ff;
  logic [1:0]  pinSync_ff;
  logic [1:0]  pinPrev_ff;
  logic        irqA_ff;
  logic        irqB_ff;
  logic        ovf_ff;
  logic        ext_ff;

  cmp_if ifA ();
  cmp_if ifB ();

  compare_unit u_cmpA (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .c       (ifA)
  );
  compare_unit u_cmpB (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .c       (ifB)
  );

  // Bus slave: one wait state, answer at the second edge
  wire        reqOn  = read | write;
  wire        accept = reqOn & (busSt_ff == BUS_ACK);
  wire [11:0] regIdx = address[ADDR_W-1:2];
  wire [7:0]  wByte  = writedata[7:0];

  wire        wrOk   = accept & write & byteenable[0];
  wire        rdOk   = accept & read;

  // Pure on its inputs so continuous assigns see every change
  function automatic logic idxIs(input logic [11:0] cur,
                                 input logic [11:0] idx);
    return cur == idx;
  endfunction

  function automatic logic ffNext(input logic       cur,
                                  input logic       wr,
                                  input logic [1:0] cmd,
                                  input logic       tog);
    logic res;
    res = cur;
    if (wr && cmd == CMD_SET)      res = 1'b1;
    else if (wr && cmd == CMD_CLR) res = 1'b0;
    else if ((wr && cmd == CMD_INV) || tog) res = ~cur;
    return res;
  endfunction

  assign waitrequest = reqOn & (busSt_ff != BUS_ACK);
  assign nxt_busSt   = (reqOn && busSt_ff == BUS_IDLE)
                       ? BUS_ACK : BUS_IDLE;
  assign readdata    = {24'h000000, rdData_ff};

  wire wrRun   = wrOk & idxIs(regIdx, IDX_RUN);
  wire wrMode  = wrOk & idxIs(regIdx, IDX_MODE);
  wire wrFfcr  = wrOk & idxIs(regIdx, IDX_FFCR);
  wire wrALo   = wrOk & idxIs(regIdx, IDX_CMPA_LO);
  wire wrAHi   = wrOk & idxIs(regIdx, IDX_CMPA_HI);
  wire wrBLo   = wrOk & idxIs(regIdx, IDX_CMPB_LO);
  wire wrBHi   = wrOk & idxIs(regIdx, IDX_CMPB_HI);
  wire rdCapAL = rdOk & idxIs(regIdx, IDX_CAPA_LO);
  wire rdCapAH = rdOk & idxIs(regIdx, IDX_CAPA_HI);
  wire rdCapBL = rdOk & idxIs(regIdx, IDX_CAPB_LO);
  wire rdCapBH = rdOk & idxIs(regIdx, IDX_CAPB_HI);

  // compare addresses fall to the zero default
  wire [7:0] rdMux =
    (regIdx == IDX_RUN)     ? (runReg_ff | RUN_RD_ONES)   :
    (regIdx == IDX_MODE)    ? (modeReg_ff | MODE_RD_ONES) :
    (regIdx == IDX_FFCR)    ? (ffcrReg_ff | FFCR_RD_ONES) :
    (regIdx == IDX_CAPA_LO) ? capA_ff[7:0]  :
    (regIdx == IDX_CAPA_HI) ? capA_ff[15:8] :
    (regIdx == IDX_CAPB_LO) ? capB_ff[7:0]  :
    (regIdx == IDX_CAPB_HI) ? capB_ff[15:8] : 8'h00;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busSt_ff  <= BUS_IDLE;
      rdData_ff <= 8'h00;
    end else begin
      busSt_ff <= nxt_busSt;
      if (read && busSt_ff == BUS_IDLE) rdData_ff <= rdMux;
    end
  end

  // buffer enable and all control clear at reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      runReg_ff  <= 8'h00;
      modeReg_ff <= 8'h00;
      ffcrReg_ff <= 8'h00;
    end else begin
      if (wrRun)  runReg_ff  <= wByte & RUN_WR_MASK;
      if (wrMode) modeReg_ff <= wByte & MODE_WR_MASK;
      if (wrFfcr) ffcrReg_ff <= wByte & FFCR_WR_MASK;
    end
  end

  wire       rde    = runReg_ff[RUN_RDE];
  wire       prun   = runReg_ff[RUN_PRUN];
  wire       cntRun = runReg_ff[RUN_CNT];
  wire       cle    = modeReg_ff[MODE_CLE];
  wire [1:0] clkSel = modeReg_ff[MODE_CLK_HI:MODE_CLK_LO];
  wire [1:0] cpm    = modeReg_ff[MODE_CPM_HI:MODE_CPM_LO];

  // Pins pass three flops; edges compare the second stage with the third
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_ff <= 2'h0;
      pinSync_ff <= 2'h0;
      pinPrev_ff <= 2'h0;
    end else begin
      pinMeta_ff <= {captureInB, captureInA};
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  wire [1:0] pinRise = pinSync_ff & ~pinPrev_ff;
  wire [1:0] pinFall = ~pinSync_ff & pinPrev_ff;

  // prescaler held at zero while stopped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)      pre_ff <= 5'h00;
    else if (!prun) pre_ff <= 5'h00;
    else            pre_ff <= pre_ff + 5'h01;
  end

  wire [PRE_W-1:0] preMask =
    (clkSel == CLK_T1) ? T1_MASK :
    (clkSel == CLK_T4) ? T4_MASK : T16_MASK;
  wire preTick = prun && ((pre_ff & preMask) == preMask);
  wire cntTick = cntRun &&
    ((clkSel == CLK_EXT) ? pinRise[0] : preTick);

  // clear on B equality instead of counting on
  wire clrHit = cle && ifB.equal;
  // wrap from all ones raises overflow
  wire ovfHit = cntTick && (uc_ff == CNT_TOP) && !clrHit;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)        uc_ff <= 16'h0000;
    else if (!cntRun) uc_ff <= 16'h0000;
    else if (cntTick) uc_ff <= clrHit ? 16'h0000
                                      : uc_ff + 16'h0001;
  end

  assign ifA.count = uc_ff;
  assign ifA.value = cmpA_ff;
  assign ifA.armed = armA_ff;
  assign ifB.count = uc_ff;
  assign ifB.value = cmpB_ff;
  assign ifB.armed = armB_ff;

  // enable bit picks buffer or bypass
  // buffer mode sends writes to the buffer only
  wire wrADirLo = wrALo && !rde;
  wire wrADirHi = wrAHi && !rde;
  // only with both byte flags set
  wire xfer = rde && bufLo_ff && bufHi_ff && ifB.hit;

  // compare and buffer storage carry no reset
  always_ff @(posedge ref_clk) begin
    if (wrALo) buf_ff[7:0]  <= wByte;
    if (wrAHi) buf_ff[15:8] <= wByte;
    if (wrBLo) cmpB_ff[7:0]  <= wByte;
    if (wrBHi) cmpB_ff[15:8] <= wByte;
  end

  always_ff @(posedge ref_clk) begin
    if (xfer) begin
      cmpA_ff <= buf_ff;
    end else begin
      if (wrADirLo) cmpA_ff[7:0]  <= wByte;
      if (wrADirHi) cmpA_ff[15:8] <= wByte;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      armA_ff  <= 1'b0;
      armB_ff  <= 1'b0;
      bufLo_ff <= 1'b0;
      bufHi_ff <= 1'b0;
    end else begin
      // direct low byte disarms, direct high byte or buffer copy arms
      if (wrADirLo)          armA_ff <= 1'b0;
      else if (wrADirHi || xfer) armA_ff <= 1'b1;
      if (wrBLo)      armB_ff <= 1'b0;
      else if (wrBHi) armB_ff <= 1'b1;
      // flags set per byte, set beats the clear
      if (wrALo && rde) bufLo_ff <= 1'b1;
      else if (xfer)    bufLo_ff <= 1'b0;
      if (wrAHi && rde) bufHi_ff <= 1'b1;
      else if (xfer)    bufHi_ff <= 1'b0;
    end
  end

  wire ffARise = ffA_ff && !ffAPrev_ff;
  wire ffAFall = !ffA_ff && ffAPrev_ff;
  wire selA =
    (cpm == CPM_IN0) ? pinRise[0] :
    (cpm == CPM_IN1) ? pinRise[1] :
    (cpm == CPM_FFA) ? ffARise    : 1'b0;
  wire selB =
    (cpm == CPM_IN0) ? pinFall[0] :
    (cpm == CPM_IN1) ? pinFall[1] :
    (cpm == CPM_FFA) ? ffAFall    : 1'b0;
  wire extEdge = (cpm == CPM_IN1) ? pinFall[1] : pinRise[1];

  // zero written to the soft bit, prescaler running
  wire softCap = wrMode && !wByte[MODE_SWCAP] && prun;
  // latch blocked between low and high byte reads
  wire capAEv = (softCap || selA) && !lockA_ff;
  wire capBEv = selB && !lockB_ff;

  // captures change only by counter latch
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capA_ff  <= 16'h0000;
      capB_ff  <= 16'h0000;
      lockA_ff <= 1'b0;
      lockB_ff <= 1'b0;
    end else begin
      if (capAEv) capA_ff <= uc_ff;
      if (capBEv) capB_ff <= uc_ff;
      if (rdCapAL)      lockA_ff <= 1'b1;
      else if (rdCapAH) lockA_ff <= 1'b0;
      if (rdCapBL)      lockB_ff <= 1'b1;
      else if (rdCapBH) lockB_ff <= 1'b0;
    end
  end

  // each toggle source gated by its enable
  wire togA = (ifA.hit && ffcrReg_ff[FFCR_MA_EN])
           || (ifB.hit && ffcrReg_ff[FFCR_MB_EN])
           || (capAEv && ffcrReg_ff[FFCR_CAPA_EN]);
  wire togB = capBEv && ffcrReg_ff[FFCR_CAPB_EN];
  wire [1:0] cmdA = wByte[FFCR_A_CMD_HI:FFCR_A_CMD_LO];
  wire [1:0] cmdB = wByte[FFCR_B_CMD_HI:FFCR_B_CMD_LO];

  // no reset, software sets the start value
  // command wins, a double invert counts once
  always_ff @(posedge ref_clk) begin
    ffA_ff     <= ffNext(ffA_ff, wrFfcr, cmdA, togA);
    ffB_ff     <= ffNext(ffB_ff, wrFfcr, cmdB, togB);
    ffAPrev_ff <= ffA_ff;
  end

  // toggle states to the pin multiplexer
  assign timerOutA = ffA_ff;
  assign timerOutB = ffB_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqA_ff <= 1'b0;
      irqB_ff <= 1'b0;
      ovf_ff  <= 1'b0;
      ext_ff  <= 1'b0;
    end else begin
      irqA_ff <= ifA.hit;
      irqB_ff <= ifB.hit;
      ovf_ff  <= ovfHit;
      ext_ff  <= (cpm != CPM_OFF) && extEdge;
    end
  end

  assign matchIrqA   = irqA_ff;
  assign matchIrqB   = irqB_ff;
  assign overflowIrq = ovf_ff;
  assign extIrq      = ext_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence busAnswer;
    waitrequest ##1 !waitrequest;
  endsequence

  chk_bus_one_wait: assert property (
    (reqOn && busSt_ff == BUS_IDLE) |-> busAnswer)
    else $error("bus answer not after one wait state");

  chk_clear_on_match: assert property (
    (cntTick && cle && ifB.equal) |=> (uc_ff == 16'h0000))
    else $error("counter not cleared on B match");

  chk_overflow_pulse: assert property (
    ovfHit |=> overflowIrq ##1 !overflowIrq)
    else $error("overflow pulse missing or stuck");

  chk_prescale_stop: assert property (
    !prun |=> (pre_ff == 5'h00))
    else $error("prescaler not cleared while stopped");

  sequence copyDone;
    ##1 (cmpA_ff == $past(buf_ff)) && armA_ff;
  endsequence

  chk_buffer_copy: assert property (
    xfer |-> copyDone)
    else $error("buffer not copied on B match");

  chk_partial_hold: assert property (
    (rde && ifB.hit && !(bufLo_ff && bufHi_ff))
      |=> (cmpA_ff == $past(cmpA_ff)))
    else $error("compare A changed from partial buffer");

  chk_flags_clear: assert property (
    (xfer && !wrALo && !wrAHi) |=> (!bufLo_ff && !bufHi_ff))
    else $error("buffer flags survived a copy");

  chk_write_only: assert property (
    (read && waitrequest && regIdx >= IDX_CMPA_LO
      && regIdx <= IDX_CMPB_HI) |=> (readdata == 32'h0))
    else $error("compare register value leaked on read");

  chk_soft_capture: assert property (
    (softCap && !lockA_ff) |=> (capA_ff == $past(uc_ff)))
    else $error("soft capture did not latch counter");

  chk_read_lock: assert property (
    lockA_ff |=> (capA_ff == $past(capA_ff)))
    else $error("capture A moved during split read");

  chk_cmd_set: assert property (
    (wrFfcr && cmdA == CMD_SET) |=> timerOutA)
    else $error("set command did not force output A");
endmodule

/* shared/cmp_if.sv */
/*
  Link between the channel and one comparator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface cmp_if;
  logic [15:0] count;
  logic [15:0] value;
  logic        armed;
  logic        equal;
  logic        hit;
  modport unit (input count, value, armed, output equal, hit);
  modport top  (output count, value, armed, input equal, hit);
endinterface

/* shared/timer_pkg.sv */
/*
  Constants for one 16-bit compare/capture timer channel.
  Assumes a 32-bit Avalon-MM slave where each 8-bit register
  sits in the low lane of one word at byte address 4 * index.
*/
package timer_pkg;
  localparam int ADDR_W = 14;

  // Register indices, byte address is four times the index
  localparam logic [11:0] IDX_RUN     = 12'h180;
  localparam logic [11:0] IDX_MODE    = 12'h182;
  localparam logic [11:0] IDX_FFCR    = 12'h183;
  localparam logic [11:0] IDX_CMPA_LO = 12'h188;
  localparam logic [11:0] IDX_CMPA_HI = 12'h189;
  localparam logic [11:0] IDX_CMPB_LO = 12'h18a;
  localparam logic [11:0] IDX_CMPB_HI = 12'h18b;
  localparam logic [11:0] IDX_CAPA_LO = 12'h18c;
  localparam logic [11:0] IDX_CAPA_HI = 12'h18d;
  localparam logic [11:0] IDX_CAPB_LO = 12'h18e;
  localparam logic [11:0] IDX_CAPB_HI = 12'h18f;

  // Run register fields
  localparam int RUN_RDE  = 7;
  localparam int RUN_PRUN = 2;
  localparam int RUN_CNT  = 0;
  localparam logic [7:0] RUN_WR_MASK = 8'hcd;
  localparam logic [7:0] RUN_RD_ONES = 8'h32;

  // Mode register fields
  localparam int MODE_SWCAP  = 5;
  localparam int MODE_CPM_HI = 4;
  localparam int MODE_CPM_LO = 3;
  localparam int MODE_CLE    = 2;
  localparam int MODE_CLK_HI = 1;
  localparam int MODE_CLK_LO = 0;
  localparam logic [7:0] MODE_WR_MASK = 8'hdf;
  localparam logic [7:0] MODE_RD_ONES = 8'h20;

  // Flip-flop control register fields
  localparam int FFCR_B_CMD_HI = 7;
  localparam int FFCR_B_CMD_LO = 6;
  localparam int FFCR_CAPA_EN  = 5;
  localparam int FFCR_MB_EN    = 4;
  localparam int FFCR_MA_EN    = 3;
  localparam int FFCR_CAPB_EN  = 2;
  localparam int FFCR_A_CMD_HI = 1;
  localparam int FFCR_A_CMD_LO = 0;
  localparam logic [7:0] FFCR_WR_MASK = 8'h3c;
  localparam logic [7:0] FFCR_RD_ONES = 8'hc3;

  localparam logic [1:0] CMD_INV  = 2'h0;
  localparam logic [1:0] CMD_SET  = 2'h1;
  localparam logic [1:0] CMD_CLR  = 2'h2;

  localparam logic [1:0] CPM_OFF = 2'h0;
  localparam logic [1:0] CPM_IN0 = 2'h1;
  localparam logic [1:0] CPM_IN1 = 2'h2;
  localparam logic [1:0] CPM_FFA = 2'h3;

  localparam logic [1:0] CLK_EXT = 2'h0;
  localparam logic [1:0] CLK_T1  = 2'h1;
  localparam logic [1:0] CLK_T4  = 2'h2;

  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] T1_MASK  = 5'h01;
  localparam logic [PRE_W-1:0] T4_MASK  = 5'h07;
  localparam logic [PRE_W-1:0] T16_MASK = 5'h1f;
  localparam logic [15:0] CNT_TOP = 16'hffff;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_t;
endpackage

/* tb/cpu_master.sv */
/*
  CPU model: byte register accesses over Avalon-MM.
  Assumes the slave answers by lowering waitrequest.
*/
`timescale 1ns/100ps
module cpu_master
  import timer_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              waitrequest,
  input  wire logic [31:0]       readdata,
  output logic      [ADDR_W-1:0] address,
  output logic                   read,
  output logic                   write,
  output logic      [31:0]       writedata,
  output logic      [3:0]        byteenable
);
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end

  task automatic xfer(input logic isWr, input logic [11:0] idx,
                      input logic [7:0] din, output logic [7:0] dout);
    @(posedge ref_clk);
    address    <= {idx, 2'h0};
    read       <= ~isWr;
    write      <= isWr;
    writedata  <= {24'h0, din};
    byteenable <= 4'h1;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0)
      @(posedge ref_clk);
    dout = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    // Released data must not look like the last value
    writedata <= ~writedata;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    xfer(1'b1, idx, d, unused);
  endtask

  task automatic rd(input logic [11:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask

  task automatic wr16(input logic [11:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 12'h1, v[15:8]);
  endtask

  task automatic rd16(input logic [11:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 12'h1, v[15:8]);
  endtask
endmodule

/* tb/tb_top.sv */
/*
  Self-checking bench for the timer channel.
  Assumes the CPU model for register traffic and drives pins.
*/
`timescale 1ns/100ps
module tb_top;
  import timer_pkg::*;
  logic              ref_clk;
  logic              rstn;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [1:0]        pins;
  logic              timerOutA;
  logic              timerOutB;
  logic              matchIrqA;
  logic              matchIrqB;
  logic              overflowIrq;
  logic              extIrq;
  int                numErrors = 0;
  int                numChecks = 0;
  int                seed = 13822;
  int                cntA = 0;
  int                cntExt = 0;
  int                cntOvf = 0;
  int                n;
  int                k;
  logic [15:0]       vb, va, vx, got;
  logic [7:0]        b;
  logic              ffOld;
  logic [1:0]        cmds [5] = '{CMD_SET, CMD_INV, CMD_INV, CMD_CLR,
                                  CMD_INV};
  logic [4:0]        expBits = 5'h15;

  timer_compare_capture_channel DUT (
    .ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .captureInA(pins[0]), .captureInB(pins[1]),
    .timerOutA(timerOutA), .timerOutB(timerOutB),
    .matchIrqA(matchIrqA), .matchIrqB(matchIrqB),
    .overflowIrq(overflowIrq), .extIrq(extIrq)
  );

  cpu_master cpu (
    .ref_clk(ref_clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (matchIrqA === 1'b1)
      cntA <= cntA + 1;
    if (extIrq === 1'b1)
      cntExt <= cntExt + 1;
    if (overflowIrq === 1'b1)
      cntOvf <= cntOvf + 1;
  end

  function automatic int gapExp(input logic [15:0] v);
    return 2 * (int'(v) + 1);
  endfunction

  task automatic check(input logic [15:0] g, input logic [15:0] e,
                       input string what);
    numChecks++;
    if (g !== e) begin
      numErrors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic wrapUp;
    $display("errors %0d checks %0d", numErrors, numChecks);
    if (numErrors == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic waitIrq(input logic selB, output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      cyc++;
    end while ((selB ? matchIrqB : matchIrqA) !== 1'b1 && cyc < 4000);
    if (cyc >= 4000) begin
      numErrors++;
      $display("MISMATCH %0t interrupt wait ran out", $time);
    end
  endtask

  task automatic gapCheck(input logic [15:0] v);
    waitIrq(1'b1, n);
    ffOld = timerOutA;
    waitIrq(1'b0, n);
    check(16'(n), 16'(gapExp(v)), "B to A spacing");
    check(timerOutA, !ffOld, "toggle on match");
  endtask

  // Levels held long enough for the pin synchroniser
  task automatic pinPulse(input logic selB, input int cnt);
    repeat (cnt) begin
      @(posedge ref_clk);
      pins[selB] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pins[selB] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    numErrors++;
    $display("MISMATCH %0t run did not finish", $time);
    wrapUp();
  end

  initial begin
    pins = 2'h0;
    rstn = 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    cpu.rd(IDX_RUN, b);
    check(b, 8'h32, "run reset value");
    cpu.rd(IDX_CMPA_LO, b);
    check(b, 8'h00, "compare read");
    cpu.rd(12'h1ff, b);
    check(b, 8'h00, "unmapped read");
    for (k = 0; k < 5; k++) begin
      cpu.wr(IDX_FFCR, {cmds[k], 4'h0, cmds[k]});
      @(negedge ref_clk);
      check(timerOutA, expBits[k], "ff A command");
      check(timerOutB, expBits[k], "ff B command");
    end
    vb = 16'h0050 + 16'($random(seed) & 63);
    va = 16'h0008 + 16'($random(seed) & 63);
    cpu.wr16(IDX_CMPB_LO, vb);
    cpu.wr16(IDX_CMPA_LO, va);
    cpu.wr(IDX_MODE, 8'h25);
    cpu.wr(IDX_FFCR, 8'hcb);
    cpu.wr(IDX_RUN, 8'h05);
    waitIrq(1'b1, n);
    waitIrq(1'b1, n);
    check(16'(n), 16'(gapExp(vb)), "B period");
    gapCheck(va);
    waitIrq(1'b1, n);
    cpu.wr(IDX_CMPA_LO, va[7:0]);
    k = cntA;
    repeat (4 * (int'(vb) + 1)) @(posedge ref_clk);
    check(16'(cntA - k), 16'h0, "low byte alone");
    cpu.wr(IDX_CMPA_HI, va[15:8]);
    gapCheck(va);
    vx = 16'h0008 + 16'($random(seed) & 63);
    waitIrq(1'b1, n);
    // buffer enabled before compare A loaded
    cpu.wr(IDX_RUN, 8'h85);
    cpu.wr16(IDX_CMPA_LO, vx);
    gapCheck(vx);
    va = vx ^ 16'h0001;
    waitIrq(1'b1, n);
    cpu.wr(IDX_CMPA_LO, va[7:0]);
    gapCheck(vx);
    waitIrq(1'b1, n);
    cpu.wr(IDX_CMPA_HI, 8'h00);
    gapCheck(va);
    cpu.wr(IDX_RUN, 8'h04);
    cpu.wr(IDX_FFCR, 8'hc7);
    cpu.wr(IDX_MODE, 8'h30);
    cpu.wr(IDX_RUN, 8'h05);
    k = 5 + ($random(seed) & 15);
    pinPulse(1'b0, k);
    cpu.wr(IDX_MODE, 8'h10);
    cpu.wr(IDX_CAPA_LO, 8'ha5);
    cpu.rd16(IDX_CAPA_LO, got);
    check(got, 16'(k), "soft capture");
    cpu.rd(IDX_CAPA_LO, b);
    pinPulse(1'b0, k);
    cpu.wr(IDX_MODE, 8'h10);
    cpu.rd(IDX_CAPA_HI, b);
    cpu.rd16(IDX_CAPA_LO, got);
    check(got, 16'(k), "capture while locked");
    ffOld = timerOutB;
    n = cntExt;
    pinPulse(1'b1, 1);
    cpu.rd16(IDX_CAPA_LO, got);
    check(got, 16'(2 * k), "capture A on rise");
    cpu.rd16(IDX_CAPB_LO, got);
    check(got, 16'(2 * k), "capture B on fall");
    check(16'(cntExt - n), 16'h1, "edge interrupt");
    check(timerOutB, !ffOld, "toggle on capture");
    cpu.wr(IDX_MODE, 8'h20);
    n = cntExt;
    pinPulse(1'b1, 1);
    check(16'(cntExt - n), 16'h0, "edge interrupt off");
    cpu.wr(IDX_MODE, 8'h28);
    n = cntExt;
    pinPulse(1'b0, 1);
    pinPulse(1'b1, 1);
    cpu.rd16(IDX_CAPA_LO, got);
    check(got, 16'(2 * k), "capture A on pin A rise");
    cpu.rd16(IDX_CAPB_LO, got);
    check(got, 16'(2 * k + 1), "capture B on pin A fall");
    check(16'(cntExt - n), 16'h1, "edge interrupt on rise");
    cpu.wr(IDX_MODE, 8'h38);
    cpu.wr(IDX_FFCR, 8'hc6);
    cpu.wr(IDX_FFCR, 8'hc5);
    cpu.rd16(IDX_CAPA_LO, got);
    check(got, 16'(2 * k + 1), "capture A on ff A rise");
    check(16'(cntOvf), 16'h0, "no wrap seen");
    wrapUp();
  end
endmodule
